/* mcch_pkg.sv */
// Shared constants of the meter capture command handler.
package mcch_pkg;
    // Request and answer codes.
    localparam logic [7:0] CODE_ACQ     = 8'h47;
    localparam logic [7:0] CODE_START   = 8'h4e;
    localparam logic [7:0] CODE_STOP    = 8'h4f;
    localparam logic [7:0] RESP_CODE    = 8'h52;
    localparam logic [7:0] ACK_CODE     = 8'h7e;
    localparam logic [7:0] LEN_ACQ      = 8'h26;
    localparam logic [7:0] LEN_RUNCMD   = 8'h01;
    localparam logic [7:0] FLAG_SET     = 8'h01;
    // Byte positions inside an acquisition request, counted from the code byte.
    localparam logic [5:0] IDX_FIRST    = 6'h02;
    localparam logic [5:0] IDX_FLAG_LO  = 6'h03;
    localparam logic [5:0] IDX_FLAG_HI  = 6'h25;
    localparam logic [5:0] IDX_M_HI     = 6'h26;
    localparam logic [5:0] IDX_M_LO     = 6'h27;
    localparam logic [1:0] FLAG_PAD_POS = 2'h3;
    localparam int         NUM_QTY      = 9;
    // Buffer geometry: 67 sets of 7 words, 1876 bytes per buffer.
    localparam int         SET_COUNT    = 67;
    localparam int         SET_WORDS    = 7;
    localparam int         BUF_BYTES    = SET_COUNT * SET_WORDS * 4;
    localparam logic [8:0] BUF_WORDS    = 9'(BUF_BYTES / 4);
    localparam logic [8:0] TX_WORDS     = 9'h086;
    localparam int         TX_BYTES     = 402;
    localparam int         SAMPLE_W     = 32;
    localparam int         SENT_W       = 24;
    localparam int         BANK_DEPTH   = 512;
    localparam int         STREAM_DEPTH = 8;
    // Values written to the run register of the metering core.
    localparam logic       RUN_ON       = 1'b1;
    localparam logic       RUN_OFF      = 1'b0;
endpackage

/* mcch_fifo.sv */
// Parameterised FIFO with a registered read port, used for the banks and the stream.
`timescale 1ns/1ps
module mcch_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Fill side.
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side.
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             mem_empty, mem_full, push, load;

    assign mem_empty = (wr_q == rd_q);
    assign mem_full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !mem_full;
    assign push      = in_valid && !mem_full;
    // The output register is refilled whenever it is empty or being taken.
    assign load      = !mem_empty && (!ov_q || out_ready);
    assign out_valid = ov_q;
    assign out_data  = od_q;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = load ? rd_q + 1'b1 : rd_q;
        ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = load ? mem[rd_q[AW-1:0]] : od_q;
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end
endmodule

/* mcch_top.sv */
// Command handler: request parser, ping-pong capture and truncated streaming to the host.
//
// Functional notes
// - Acquisition request opens with 0x47 and a length byte of 38.
// - Each quantity is requested by three consecutive flag bytes equal to one.
// - Bytes 38 and 39 give M, MSB first; acquire (2M+1) buffers of 67 sets.
// - After the request, enable the capture port and fill buffer zero, 1876 bytes.
// - While the next buffer fills, send 134 24-bit words from the full one.
// - Buffers alternate continuously between filling and sending.
// - Only the low 24 bits of each 32-bit sample are sent.
// - Every stream frame starts with 0x52, words follow MSB byte first.
// - Start request 0x4e, length 1, one byte: write one to the run register.
// - Stop request 0x4f, length 1, one byte: write zero to the run register.
// - Start and stop are answered with 0x52 then 0x7e.
`timescale 1ns/1ps
module mcch_top (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Request bytes from the host.
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    // Answer bytes to the host.
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Fast capture port.
    output logic             cap_enable,
    input  wire logic [31:0] cap_data,
    input  wire logic        cap_valid,
    output logic             cap_ready,
    // Run register write and selected quantities.
    output logic             run_wr,
    output logic             run_value,
    output logic      [8:0]  sel_mask
);
    typedef enum logic [1:0] {
        RX_CODE = 2'h0,
        RX_LEN  = 2'h1,
        RX_BODY = 2'h2
    } mcch_rx_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_HDR  = 3'h1,
        TX_W2   = 3'h2,
        TX_W1   = 3'h3,
        TX_W0   = 3'h4,
        TX_ACK1 = 3'h5,
        TX_ACK2 = 3'h6
    } mcch_tx_t;

    // ---------------- Request parser ----------------
    mcch_rx_t    rx_q, rx_d;
    logic [7:0]  code_q, code_d, left_q, left_d, len_q, len_d;
    logic [5:0]  idx_q, idx_d;
    logic [8:0]  flag_q, flag_d, sel_q, sel_d;
    logic [15:0] m_q, m_d;
    logic        run_wr_q, run_wr_d, run_q, run_d, ack_q, ack_d, acq_go;
    logic [5:0]  rel;
    logic        ack_taken;

    assign rel = idx_q - mcch_pkg::IDX_FLAG_LO;

    always_comb begin
        rx_d     = rx_q;
        code_d   = code_q;
        left_d   = left_q;
        len_d    = len_q;
        idx_d    = idx_q;
        flag_d   = flag_q;
        sel_d    = sel_q;
        m_d      = m_q;
        run_wr_d = 1'b0;
        run_d    = run_q;
        ack_d    = ack_q && !ack_taken;
        acq_go   = 1'b0;
        if (rx_valid) begin
            case (rx_q)
                RX_CODE: begin
                    code_d = rx_data;
                    rx_d   = RX_LEN;
                end
                RX_LEN: begin
                    left_d = rx_data;
                    len_d  = rx_data;
                    idx_d  = mcch_pkg::IDX_FIRST;
                    flag_d = '1;
                    rx_d   = (rx_data == 8'h00) ? RX_CODE : RX_BODY;
                end
                RX_BODY: begin
                    idx_d  = idx_q + 6'h01;
                    left_d = left_q - 8'h01;
                    // Three flag bytes per quantity, the fourth of each group is padding.
                    if (idx_q >= mcch_pkg::IDX_FLAG_LO && idx_q <= mcch_pkg::IDX_FLAG_HI &&
                        rel[1:0] != mcch_pkg::FLAG_PAD_POS && rx_data != mcch_pkg::FLAG_SET) begin
                        flag_d[rel[5:2]] = 1'b0;
                    end
                    if (idx_q == mcch_pkg::IDX_M_HI) begin
                        m_d[15:8] = rx_data;
                    end
                    if (idx_q == mcch_pkg::IDX_M_LO) begin
                        m_d[7:0] = rx_data;
                    end
                    // Act only on the last counted byte; other codes are dropped here.
                    if (left_q == 8'h01) begin
                        rx_d = RX_CODE;
                        if (code_q == mcch_pkg::CODE_ACQ && len_q == mcch_pkg::LEN_ACQ) begin
                            acq_go = 1'b1;
                            sel_d  = flag_d;
                        end else if (code_q == mcch_pkg::CODE_START &&
                                     len_q == mcch_pkg::LEN_RUNCMD) begin
                            run_wr_d = 1'b1;
                            run_d    = mcch_pkg::RUN_ON;
                            ack_d    = 1'b1;
                        end else if (code_q == mcch_pkg::CODE_STOP &&
                                     len_q == mcch_pkg::LEN_RUNCMD) begin
                            run_wr_d = 1'b1;
                            run_d    = mcch_pkg::RUN_OFF;
                            ack_d    = 1'b1;
                        end
                    end
                end
                default: rx_d = RX_CODE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q     <= RX_CODE;
            code_q   <= 8'h00;
            left_q   <= 8'h00;
            len_q    <= 8'h00;
            idx_q    <= 6'h00;
            flag_q   <= 9'h000;
            sel_q    <= 9'h000;
            m_q      <= 16'h0000;
            run_wr_q <= 1'b0;
            run_q    <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            rx_q     <= rx_d;
            code_q   <= code_d;
            left_q   <= left_d;
            len_q    <= len_d;
            idx_q    <= idx_d;
            flag_q   <= flag_d;
            sel_q    <= sel_d;
            m_q      <= m_d;
            run_wr_q <= run_wr_d;
            run_q    <= run_d;
            ack_q    <= ack_d;
        end
    end

    assign run_wr    = run_wr_q;
    assign run_value = run_q;
    assign sel_mask  = sel_q;

    // ---------------- Ping-pong capture ----------------
    logic [31:0] bank_out [2];
    logic [1:0]  bank_in_valid, bank_in_ready, bank_out_valid, bank_out_ready;
    logic [1:0]  full_q, full_d;
    logic        wr_bank_q, wr_bank_d, rd_bank_q, rd_bank_d, cap_en_q, cap_en_d;
    logic [8:0]  fill_q, fill_d, drain_q, drain_d;
    logic [16:0] bufs_q, bufs_d;
    logic        take, fill_done, pop, drain_done;
    logic        st_in_valid, st_in_ready, st_out_valid, st_out_ready;
    logic [23:0] st_out;

    for (genvar b = 0; b < 2; b++) begin : g_bank
        mcch_fifo #(.WIDTH(mcch_pkg::SAMPLE_W), .DEPTH(mcch_pkg::BANK_DEPTH)) u_bank (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .in_data   (cap_data),
            .in_valid  (bank_in_valid[b]),
            .in_ready  (bank_in_ready[b]),
            .out_data  (bank_out[b]),
            .out_valid (bank_out_valid[b]),
            .out_ready (bank_out_ready[b])
        );
        assign bank_in_valid[b]  = take && (wr_bank_q == 1'(b));
        assign bank_out_ready[b] = pop && (rd_bank_q == 1'(b));
    end

    // A bank that is still being sent holds off capture; samples then wait at the port.
    assign cap_ready  = cap_en_q && !full_q[wr_bank_q] && bank_in_ready[wr_bank_q];
    assign take       = cap_valid && cap_ready;
    assign fill_done  = take && (fill_q == mcch_pkg::BUF_WORDS - 9'h001);
    assign st_in_valid = full_q[rd_bank_q] && bank_out_valid[rd_bank_q] &&
                         (drain_q < mcch_pkg::TX_WORDS);
    // Words past the streamed part are drained without being sent.
    assign pop        = full_q[rd_bank_q] && bank_out_valid[rd_bank_q] &&
                        ((drain_q >= mcch_pkg::TX_WORDS) || st_in_ready);
    assign drain_done = pop && (drain_q == mcch_pkg::BUF_WORDS - 9'h001);
    assign cap_enable = cap_en_q;

    always_comb begin
        wr_bank_d = wr_bank_q;
        rd_bank_d = rd_bank_q;
        fill_d    = take ? fill_q + 9'h001 : fill_q;
        drain_d   = pop ? drain_q + 9'h001 : drain_q;
        full_d    = full_q;
        bufs_d    = bufs_q;
        cap_en_d  = cap_en_q;
        if (acq_go && !cap_en_q) begin
            bufs_d   = {m_d, 1'b1};
            cap_en_d = 1'b1;
            fill_d   = 9'h000;
        end
        if (fill_done) begin
            fill_d            = 9'h000;
            full_d[wr_bank_q] = 1'b1;
            wr_bank_d         = !wr_bank_q;
            bufs_d            = bufs_q - 17'h00001;
            cap_en_d          = (bufs_q != 17'h00001);
        end
        if (drain_done) begin
            drain_d           = 9'h000;
            full_d[rd_bank_q] = 1'b0;
            rd_bank_d         = !rd_bank_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_bank_q <= 1'b0;
            rd_bank_q <= 1'b0;
            fill_q    <= 9'h000;
            drain_q   <= 9'h000;
            full_q    <= 2'h0;
            bufs_q    <= 17'h00000;
            cap_en_q  <= 1'b0;
        end else begin
            wr_bank_q <= wr_bank_d;
            rd_bank_q <= rd_bank_d;
            fill_q    <= fill_d;
            drain_q   <= drain_d;
            full_q    <= full_d;
            bufs_q    <= bufs_d;
            cap_en_q  <= cap_en_d;
        end
    end

    mcch_fifo #(.WIDTH(mcch_pkg::SENT_W), .DEPTH(mcch_pkg::STREAM_DEPTH)) u_stream (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (bank_out[rd_bank_q][23:0]),
        .in_valid  (st_in_valid),
        .in_ready  (st_in_ready),
        .out_data  (st_out),
        .out_valid (st_out_valid),
        .out_ready (st_out_ready)
    );

    // ---------------- Answer serializer ----------------
    mcch_tx_t    tx_q, tx_d;
    logic [7:0]  byte_q, byte_d;
    logic [23:0] word_q, word_d;
    logic [7:0]  wcnt_q, wcnt_d;
    logic        adv;

    assign tx_valid  = (tx_q != TX_IDLE);
    assign tx_data   = byte_q;
    assign adv       = tx_valid && tx_ready;
    assign ack_taken = (tx_q == TX_IDLE) && (wcnt_q == 8'h00) && ack_q;

    always_comb begin
        tx_d         = tx_q;
        byte_d       = byte_q;
        word_d       = word_q;
        wcnt_d       = wcnt_q;
        st_out_ready = 1'b0;
        case (tx_q)
            TX_IDLE: begin
                // An acknowledge never splits a stream frame.
                if (ack_taken) begin
                    tx_d   = TX_ACK1;
                    byte_d = mcch_pkg::RESP_CODE;
                end else if (st_out_valid && wcnt_q == 8'h00) begin
                    tx_d   = TX_HDR;
                    byte_d = mcch_pkg::RESP_CODE;
                end else if (st_out_valid) begin
                    st_out_ready = 1'b1;
                    word_d       = st_out;
                    tx_d         = TX_W2;
                    byte_d       = st_out[23:16];
                end
            end
            TX_HDR: begin
                if (tx_ready) begin
                    st_out_ready = 1'b1;
                    word_d       = st_out;
                    tx_d         = TX_W2;
                    byte_d       = st_out[23:16];
                end
            end
            TX_W2: begin
                if (tx_ready) begin
                    tx_d   = TX_W1;
                    byte_d = word_q[15:8];
                end
            end
            TX_W1: begin
                if (tx_ready) begin
                    tx_d   = TX_W0;
                    byte_d = word_q[7:0];
                end
            end
            TX_W0: begin
                if (tx_ready) begin
                    tx_d   = TX_IDLE;
                    wcnt_d = (wcnt_q == 8'(mcch_pkg::TX_WORDS - 9'h001)) ? 8'h00
                                                                         : wcnt_q + 8'h01;
                end
            end
            TX_ACK1: begin
                if (tx_ready) begin
                    tx_d   = TX_ACK2;
                    byte_d = mcch_pkg::ACK_CODE;
                end
            end
            TX_ACK2: begin
                if (tx_ready) begin
                    tx_d = TX_IDLE;
                end
            end
            default: tx_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q   <= TX_IDLE;
            byte_q <= 8'h00;
            word_q <= 24'h000000;
            wcnt_q <= 8'h00;
        end else begin
            tx_q   <= tx_d;
            byte_q <= byte_d;
            word_q <= word_d;
            wcnt_q <= wcnt_d;
        end
    end

    // Words pushed towards the host from the bank being drained, for the stream check.
    logic [8:0] pushed_q, pushed_d;

    always_comb begin
        pushed_d = pushed_q;
        if (st_in_valid && st_in_ready) begin
            pushed_d = pushed_q + 9'h001;
        end
        if (drain_done) begin
            pushed_d = 9'h000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pushed_q <= 9'h000;
        end else begin
            pushed_q <= pushed_d;
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_start_run_write: assert property (
        rx_valid && rx_q == RX_BODY && left_q == 8'h01 && code_q == mcch_pkg::CODE_START &&
        len_q == mcch_pkg::LEN_RUNCMD |=> run_wr && run_value && ack_q)
        else $error("start request did not write one to the run register");
    a_stop_run_write: assert property (
        rx_valid && rx_q == RX_BODY && left_q == 8'h01 && code_q == mcch_pkg::CODE_STOP &&
        len_q == mcch_pkg::LEN_RUNCMD |=> run_wr && !run_value && ack_q)
        else $error("stop request did not write zero to the run register");
    a_unknown_no_write: assert property (
        run_wr |-> $past(code_q) == mcch_pkg::CODE_START || $past(code_q) == mcch_pkg::CODE_STOP)
        else $error("run register written by an unknown request");
    a_ack_pair_order: assert property (
        tx_q == TX_ACK1 && tx_ready |-> tx_data == mcch_pkg::RESP_CODE
        ##1 tx_valid && tx_data == mcch_pkg::ACK_CODE)
        else $error("acknowledge bytes out of order");
    a_frame_header: assert property (
        tx_valid && wcnt_q == 8'h00 && $past(tx_q) == TX_IDLE && tx_q != TX_ACK1 |->
        tx_data == mcch_pkg::RESP_CODE)
        else $error("stream frame does not open with the answer code");
    a_word_byte_order: assert property (
        tx_q == TX_W2 && tx_ready |=> tx_q == TX_W1 && tx_data == word_q[15:8])
        else $error("word bytes not sent most significant first");
    a_word_low_byte: assert property (
        tx_q == TX_W1 && tx_ready |=> tx_q == TX_W0 && tx_data == word_q[7:0])
        else $error("low byte of a word not sent last");
    a_stream_limit: assert property (
        drain_done |-> pushed_q == mcch_pkg::TX_WORDS)
        else $error("bank did not stream exactly the counted words");
    a_fill_swaps_bank: assert property (
        fill_done |=> wr_bank_q != $past(wr_bank_q) && full_q[$past(wr_bank_q)] && fill_q == 9'h000)
        else $error("full buffer did not hand over to the other bank");
    a_stop_after_count: assert property (
        fill_done && bufs_q == 17'h00001 |=> !cap_enable)
        else $error("capture continued past the requested buffer count");

    c_acq_started: cover property (acq_go ##1 cap_enable);
    c_bank_swap: cover property (fill_done && full_q[!wr_bank_q]);
    c_ack_sent: cover property (tx_q == TX_ACK2 && tx_ready);
endmodule

/* mcch_host_model.sv */
// Host-side model: builds requests on the byte port and gathers the answer bytes.
`timescale 1ns/1ps
module mcch_host_model (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Request bytes towards the handler.
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    // Answer bytes from the handler.
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Pacing control from the bench.
    input  wire logic       stall
);
    logic [7:0] got[$];
    logic [1:0] pace;

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        pace     = 2'h0;
    end

    // A stalling host refuses one slot in four, so the answer path meets back-pressure until the refused slot falls on the idle cycle between words.
    always @(posedge ref_clk) begin
        if (rst_n && tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        #1;
        pace     = pace + 2'h1;
        tx_ready = !stall || (pace != 2'h3);
    end

    // The byte line is inverted once released, so a stale value is never mistaken for a request.
    task automatic send_raw(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge ref_clk);
            #1;
            rx_data  = q[i];
            rx_valid = 1'b1;
        end
        @(posedge ref_clk);
        #1;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    task automatic req_run(input logic [7:0] code, input logic [7:0] anyb);
        send_raw({code, mcch_pkg::LEN_RUNCMD, anyb});
    endtask

    task automatic req_acq(input logic [8:0] mask, input logic [15:0] m, input logic [8:0] part);
        logic [7:0] q[$];
        q = {mcch_pkg::CODE_ACQ, mcch_pkg::LEN_ACQ};
        for (int k = 0; k < 9; k++) begin
            q.push_back(k == 1 ? 8'h01 : 8'h00);
            q.push_back((mask[k] || part[k]) ? 8'h01 : 8'h00);
            q.push_back((mask[k] || part[k]) ? 8'h01 : 8'h00);
            q.push_back(mask[k] ? 8'h01 : 8'h00);
        end
        q.push_back(m[15:8]);
        q.push_back(m[7:0]);
        send_raw(q);
    endtask
endmodule

/* mcch_top_bench.sv */
// Self-checking bench of the meter capture command handler.
`timescale 1ns/1ps
module mcch_top_bench;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        cap_enable;
    logic [31:0] cap_data;
    logic        cap_valid;
    logic        cap_ready;
    logic        run_wr;
    logic        run_value;
    logic [8:0]  sel_mask;
    logic        stall;
    logic        wr_val;
    int          err_total;
    int          checks;
    int          taken;
    int          wr_seen;

    mcch_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .cap_enable(cap_enable),
        .cap_data(cap_data), .cap_valid(cap_valid), .cap_ready(cap_ready), .run_wr(run_wr),
        .run_value(run_value), .sel_mask(sel_mask));

    mcch_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .stall(stall));

    always #50 ref_clk = ~ref_clk;

    // Upper byte is deliberately not a sign extension, so a missed truncation shows up.
    function automatic logic [31:0] smp(input int k);
        return {8'(k) ^ 8'hc6, 24'(k * 24'h010307) ^ 24'h5a3c96};
    endfunction

    always @(posedge ref_clk) begin
        if (cap_valid && cap_ready) begin
            taken = taken + 1;
        end
        if (run_wr) begin
            wr_seen = wr_seen + 1;
            wr_val  = run_value;
        end
        #1;
        cap_data = smp(taken);
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_bytes(input int n);
        int t;
        t = 0;
        while (host.got.size() < n && t < 30000) begin
            @(posedge ref_clk);
            t++;
        end
    endtask

    task automatic t_run(input logic [7:0] code, input logic val);
        int w;
        w = wr_seen;
        host.got.delete();
        host.req_run(code, 8'ha7);
        wait_bytes(2);
        repeat (5) @(posedge ref_clk);
        chk("run writes", 32'(wr_seen - w), 32'h1);
        chk("run value", wr_val, val);
        chk("ack length", host.got.size(), 32'h2);
        chk("ack first", host.got[0], mcch_pkg::RESP_CODE);
        chk("ack second", host.got[1], mcch_pkg::ACK_CODE);
    endtask

    task automatic t_refuse();
        int w;
        w = wr_seen;
        host.got.delete();
        host.send_raw({8'h33, 8'h02, mcch_pkg::CODE_STOP, 8'h01});
        host.send_raw({mcch_pkg::CODE_STOP, 8'h02, 8'h11, 8'h22});
        host.send_raw({mcch_pkg::CODE_STOP, 8'h00});
        repeat (10) @(posedge ref_clk);
        chk("refused writes", 32'(wr_seen - w), 32'h0);
        chk("refused answers", host.got.size(), 32'h0);
        chk("run value kept", run_value, 1'b1);
    endtask

    task automatic t_acq();
        int b;
        host.got.delete();
        stall = 1'b1;
        host.req_acq(9'h021, 16'h0001, 9'h004);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("capture enable", cap_enable, 1'b1);
        chk("selection", sel_mask, 9'h021);
        wait_bytes(3 * 403);
        repeat (20) @(posedge ref_clk);
        chk("samples taken", taken, 3 * 469);
        chk("capture end", cap_enable, 1'b0);
        chk("answer length", host.got.size(), 3 * 403);
        for (int f = 0; f < 3; f++) begin
            chk("frame header", host.got[f * 403], mcch_pkg::RESP_CODE);
            for (int w = 0; w < 134; w++) begin
                b = f * 403 + 1 + w * 3;
                chk("word", {host.got[b], host.got[b + 1], host.got[b + 2]},
                    32'(smp(f * 469 + w) & 32'h00ffffff));
            end
        end
    endtask

    task automatic t_reset();
        #1;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        chk("reset tx_valid", tx_valid, 1'b0);
        chk("reset tx_data", tx_data, 8'h00);
        chk("reset cap_enable", cap_enable, 1'b0);
        chk("reset cap_ready", cap_ready, 1'b0);
        chk("reset run_wr", run_wr, 1'b0);
        chk("reset run_value", run_value, 1'b0);
        chk("reset sel_mask", sel_mask, 9'h000);
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("idle tx_valid", tx_valid, 1'b0);
        chk("idle cap_enable", cap_enable, 1'b0);
        chk("idle run_wr", run_wr, 1'b0);
    endtask

    task automatic wrap_up();
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk   = 1'b0;
        rst_n     = 1'b0;
        cap_valid = 1'b1;
        cap_data  = 32'h00000000;
        stall     = 1'b0;
        wr_val    = 1'b0;
        err_total = 0;
        checks    = 0;
        taken     = 0;
        wr_seen   = 0;
        t_reset();
        t_run(mcch_pkg::CODE_START, 1'b1);
        t_refuse();
        t_run(mcch_pkg::CODE_STOP, 1'b0);
        t_acq();
        // A second reset in mid-run must clear the selection and leave the parser usable.
        t_reset();
        t_run(mcch_pkg::CODE_START, 1'b1);
        wrap_up();
    end

    // The whole run needs well under ten thousand cycles.
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end
endmodule
